/* crs_pkg.sv */
/*
  Constants, register map, flag layout and types shared by the core register
  set and its address-area decoder. Assumes a 10 MHz single clock domain.
*/
// Notes on behaviour
// [RULE1] Two full banks of data, address and frame-base registers; bank flag picks one.
// [RULE2] Data registers are 16 bits, also seen as 32-bit pairs and 8-bit halves.
// [RULE3] Program counter and vector base hold 20 bits; stacks and flag word 16.
// [RULE4] An interrupt keeps the top 4 program-counter bits in the save area.
// [RULE5] Signed overflow of an operation sets the overflow flag.
// [RULE6] Negative result sets the sign flag; positive result clears it.
// [RULE7] A zero result sets the zero flag.
// [RULE8] With the debug flag set the program runs one instruction at a time.
// [RULE9] General and bit addressing reach only 00000H to 0FFFFH.
// [RULE10] Special addressing reaches the whole 1-Mbyte space.
// [RULE11] Immediates are 8 or 16 bits; absolute is 16 or 20 bits.
// [RULE12] Absolute and register-indirect bit addressing stay within 0 to 1FFFH.
// [RULE13] Bit base-relative reach 31, 255 or 8191; frame-relative -16 to +15.
// [RULE14] General frame-relative is -128 to +127; base-relative reaches 65534.
// [RULE15] Branch offsets: short +2 to +9, byte and word signed ranges.
// [RULE16] Stack-relative offset is signed 8 bits, move instruction only.
// [RULE17] Opcodes are variable length in 8-bit units; 91 instructions exist.
// [RULE18] Function-register area spans 00000H to 003FFH, packed from the top.
// [RULE19] RAM from 00400H upward, ROM down from FFFFFH, vectors FFE00H up.
// [RULE20] Single-chip mode reaches internal areas only.
// [RULE21] Memory expansion mode reaches internal areas and external memory.
// [RULE22] Microprocessor mode blocks internal ROM, allows external memory.
// [RULE23] Operation mode is bits 0 and 1 of the first mode register at 00004H.
// [RULE24] Bank switching touches only the seven banked registers.
package crs_pkg;
  // ==========================================================================
  // Widths and counts
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;
  localparam int BANKED_REGS = 7;
  localparam int OPCODE_UNIT_BITS = 8;
  localparam int INSN_COUNT = 91;
  localparam int CLOCK_HZ = 10000000;

  // ==========================================================================
  // Register map, byte offsets on the bus
  localparam logic [7:0] REG_R0 = 8'h00;
  localparam logic [7:0] REG_R1 = 8'h04;
  localparam logic [7:0] REG_R2 = 8'h08;
  localparam logic [7:0] REG_R3 = 8'h0C;
  localparam logic [7:0] REG_A0 = 8'h10;
  localparam logic [7:0] REG_A1 = 8'h14;
  localparam logic [7:0] REG_FB = 8'h18;
  localparam logic [7:0] REG_SB = 8'h1C;
  localparam logic [7:0] REG_USP = 8'h20;
  localparam logic [7:0] REG_ISP = 8'h24;
  localparam logic [7:0] REG_FLG = 8'h28;
  localparam logic [7:0] REG_PC = 8'h2C;
  localparam logic [7:0] REG_VECTOR_TABLE_BASE = 8'h30;
  localparam logic [7:0] REG_R2R0 = 8'h34;
  localparam logic [7:0] REG_R3R1 = 8'h38;
  localparam logic [7:0] REG_A1A0 = 8'h3C;
  localparam logic [7:0] REG_R0L = 8'h40;
  localparam logic [7:0] REG_R0H = 8'h44;
  localparam logic [7:0] REG_R1L = 8'h48;
  localparam logic [7:0] REG_R1H = 8'h4C;
  localparam logic [7:0] REG_MODE = 8'h50;
  localparam logic [7:0] REG_AGU_CMD = 8'h54;
  localparam logic [7:0] REG_AGU_RES = 8'h58;
  localparam logic [7:0] REG_SAVE = 8'h5C;
  localparam logic [7:0] REG_INSN = 8'h60;

  // ==========================================================================
  // Bank slots, flag bits and fields
  localparam logic [2:0] BK_R0 = 3'h0;
  localparam logic [2:0] BK_R1 = 3'h1;
  localparam logic [2:0] BK_R2 = 3'h2;
  localparam logic [2:0] BK_R3 = 3'h3;
  localparam logic [2:0] BK_A0 = 3'h4;
  localparam logic [2:0] BK_A1 = 3'h5;
  localparam logic [2:0] BK_FB = 3'h6;
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam logic [15:0] FLG_RESET = 16'h0000;

  // ==========================================================================
  // Address map
  localparam logic [19:0] SFR_LO = 20'h00000;
  localparam logic [19:0] SFR_HI = 20'h003FF;
  localparam logic [19:0] MODE_REG_ADDR = 20'h00004;
  localparam logic [19:0] RAM_LO = 20'h00400;
  localparam logic [19:0] VEC_LO = 20'hFFE00;
  localparam logic [19:0] TOP_ADDR = 20'hFFFFF;
  localparam logic [19:0] GEN_LIMIT = 20'h0FFFF;
  localparam logic [15:0] BIT_LIMIT = 16'h1FFF;
  localparam logic [15:0] SB8_LIMIT = 16'h00FF;
  localparam logic [15:0] SB16_LIMIT = 16'hFFFE;
  localparam logic [15:0] BSB8_LIMIT = 16'h001F;
  localparam logic [15:0] BSB11_LIMIT = 16'h00FF;
  localparam logic [15:0] BSB16_LIMIT = 16'h1FFF;
  localparam logic [15:0] PCS_MIN = 16'h0002;
  localparam logic [15:0] PCS_MAX = 16'h0009;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPAND = 2'b01,
    MODE_RESVD = 2'b10,
    MODE_MICRO = 2'b11
  } crs_mode_t;

  typedef enum logic [2:0] {
    AREA_SFR = 3'b000,
    AREA_RAM = 3'b001,
    AREA_ROM = 3'b010,
    AREA_VEC = 3'b011,
    AREA_EXT = 3'b100
  } crs_area_t;

  typedef enum logic [3:0] {
    AG_GEN_ABS = 4'h0,
    AG_GEN_AREL = 4'h1,
    AG_GEN_SB8 = 4'h2,
    AG_GEN_SB16 = 4'h3,
    AG_GEN_FB = 4'h4,
    AG_SPC_ABS = 4'h5,
    AG_SPC_SP = 4'h6,
    AG_PC_S = 4'h7,
    AG_PC_B = 4'h8,
    AG_PC_W = 4'h9,
    AG_BIT_ABS = 4'hA,
    AG_BIT_AIND = 4'hB,
    AG_BIT_SB8 = 4'hC,
    AG_BIT_SB11 = 4'hD,
    AG_BIT_SB16 = 4'hE,
    AG_BIT_FB = 4'hF
  } crs_agmode_t;
endpackage : crs_pkg

/* crs_area_if.sv */
/*
  Carrier between the register set and its area decoder: an address and the
  active operation mode go in, the area class and an access verdict come out.
*/
`timescale 1ns/1ps
`default_nettype none
interface crs_area_if;
  import crs_pkg::*;
  logic [19:0] addr;
  crs_mode_t mode;
  crs_area_t area;
  logic allowed;
  modport requester (output addr, output mode, input area, input allowed);
  modport decoder (input addr, input mode, output area, output allowed);
endinterface : crs_area_if
`default_nettype wire

/* crs_area_decode.sv */
/*
  Area decoder for the 1-Mbyte map. Purely combinational; the size of the
  internal RAM and ROM are parameters because they differ between parts.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_area_decode
  import crs_pkg::*;
#(
  parameter int RAM_BYTES = 10240,
  parameter int ROM_BYTES = 65536
) (
  crs_area_if.decoder port
);
  localparam logic [19:0] RAM_HI = RAM_LO + 20'(RAM_BYTES - 1);
  localparam logic [19:0] ROM_LO = TOP_ADDR - 20'(ROM_BYTES - 1);

  if (RAM_BYTES < 1 || ROM_BYTES < 512 || RAM_HI >= ROM_LO) begin : g_bad_size
    $error("crs_area_decode: RAM and ROM sizes overlap or are out of range");
  end

  // ==========================================================================
  // Area class and per-mode verdict
  always_comb begin
    if (port.addr <= SFR_HI) begin
      port.area = AREA_SFR; // [RULE18]
    end else if (port.addr >= RAM_LO && port.addr <= RAM_HI) begin
      port.area = AREA_RAM; // [RULE19]
    end else if (port.addr >= VEC_LO) begin
      port.area = AREA_VEC; // [RULE19]
    end else if (port.addr >= ROM_LO) begin
      port.area = AREA_ROM; // [RULE19]
    end else begin
      port.area = AREA_EXT;
    end
    case (port.mode)
      MODE_EXPAND: port.allowed = 1'b1; // [RULE21]
      // The vector area sits inside ROM, so it is blocked with it.
      MODE_MICRO: port.allowed = (port.area != AREA_ROM) && (port.area != AREA_VEC); // [RULE22]
      default: port.allowed = (port.area != AREA_EXT); // [RULE20]
    endcase
  end
endmodule : crs_area_decode
`default_nettype wire

/* crs_regset.sv */
/*
  Core register set: two banks of general registers, shared control registers,
  flag word, operation mode, an effective-address unit and an instruction-length
  tracker, all visible to software over an AHB-Lite slave port.
  Assumes a single 10 MHz clock, a synchronous active-low reset and a master
  that leaves a data phase empty of new address phases (zero-wait slave).
*/
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module crs_regset
  import crs_pkg::*;
#(
  parameter int RAM_BYTES = 10240,
  parameter int ROM_BYTES = 65536
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic intEvent,
  input wire logic aluValid,
  input wire logic aluWide,
  input wire logic [15:0] aluResult,
  input wire logic aluOverflow,
  input wire logic opUnitValid,
  input wire logic insnDone,
  output logic stepBreak,
  output logic singleStep,
  output logic bankSel,
  output logic [1:0] opMode,
  output logic [15:0] flagWord
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0][6:0][15:0] bank;
    logic [15:0] sb;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] flag_word;
    logic [19:0] pc;
    logic [19:0] vector_table_base;

    logic [1:0] mode;
    logic [31:0] aguCmd;

    logic [3:0] savePcHi;
    logic [15:0] saveFlg;
    logic [7:0] unitCnt;
    logic [7:0] insnLen;

    logic stepBreak;
    // A write waits one cycle for its data.
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
  } crs_state_t;

  crs_state_t st_ff;
  crs_state_t nxt_st;

  crs_area_if areaBus ();

  crs_area_decode #(
    .RAM_BYTES(RAM_BYTES),
    .ROM_BYTES(ROM_BYTES)
  ) u_area (
    .port(areaBus.decoder)
  );

  if (RAM_BYTES < 1 || ROM_BYTES < 1) begin : g_bad_size
    $error("crs_regset: memory sizes must be positive");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [19:0] sext16(input logic [15:0] v);
    return {{4{v[15]}}, v};
  endfunction : sext16

  function automatic logic [19:0] sext8(input logic [15:0] v);
    return {{12{v[7]}}, v[7:0]};
  endfunction : sext8

  function automatic logic fitsSigned(input logic [15:0] v, input int bits);
    logic ok;

    ok = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i >= bits - 1 && v[i] != v[15]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : fitsSigned

  // ==========================================================================
  // Effective-address unit
  logic bnk;
  logic [15:0] disp;
  logic [15:0] aSel;
  logic [15:0] fbCur;
  logic [15:0] spCur;
  logic [19:0] ea;
  logic rangeErr;
  crs_agmode_t agMode;

  // Banked views index by the live bank flag.
  assign bnk = st_ff.flag_word[FLG_B]; // [RULE1]
  assign disp = st_ff.aguCmd[31:16];
  assign agMode = crs_agmode_t'(st_ff.aguCmd[3:0]);
  assign aSel = st_ff.aguCmd[4] ? st_ff.bank[bnk][BK_A1] : st_ff.bank[bnk][BK_A0];
  assign fbCur = st_ff.bank[bnk][BK_FB];
  assign spCur = st_ff.flag_word[FLG_U] ? st_ff.user_stack_pointer : st_ff.interrupt_stack_pointer;

  always_comb begin
    ea = 20'h00000;
    rangeErr = 1'b0;
    // A range error flags the offset; the address is still formed.
    case (agMode)
      // General forms stay inside the first 64-Kbyte page.
      AG_GEN_ABS: ea = {4'h0, disp}; // [RULE9] [RULE11]
      AG_GEN_AREL: ea = {4'h0, 16'(aSel + disp)}; // [RULE9]
      AG_GEN_SB8: begin
        ea = {4'h0, 16'(st_ff.sb + disp)};
        rangeErr = disp > SB8_LIMIT; // [RULE14]
      end
      AG_GEN_SB16: begin
        ea = {4'h0, 16'(st_ff.sb + disp)};
        rangeErr = disp > SB16_LIMIT; // [RULE14]
      end
      AG_GEN_FB: begin
        ea = {4'h0, 16'(fbCur + disp)};
        rangeErr = !fitsSigned(disp, 8); // [RULE14]
      end

      AG_SPC_ABS: ea = {st_ff.aguCmd[11:8], disp}; // [RULE10] [RULE11]
      AG_SPC_SP: begin
        ea = 20'({4'h0, spCur} + sext16(disp)); // [RULE10]
        rangeErr = !fitsSigned(disp, 8); // [RULE16]
      end

      AG_PC_S: begin
        ea = 20'(st_ff.pc + {4'h0, disp}); // [RULE15]
        rangeErr = disp < PCS_MIN || disp > PCS_MAX; // [RULE15]
      end
      AG_PC_B: begin
        ea = 20'(st_ff.pc + sext8(disp));
        rangeErr = !fitsSigned(disp, 8); // [RULE15]
      end
      AG_PC_W: ea = 20'(st_ff.pc + sext16(disp)); // [RULE15]

      // Bit forms give the byte address; the bit index rides along.
      AG_BIT_ABS: begin
        ea = {4'h0, disp};
        rangeErr = disp > BIT_LIMIT; // [RULE12]
      end
      AG_BIT_AIND: begin
        ea = {4'h0, aSel};
        rangeErr = aSel > BIT_LIMIT; // [RULE12]
      end
      AG_BIT_SB8: begin
        ea = {4'h0, 16'(st_ff.sb + disp)};
        rangeErr = disp > BSB8_LIMIT; // [RULE13]
      end
      AG_BIT_SB11: begin
        ea = {4'h0, 16'(st_ff.sb + disp)};
        rangeErr = disp > BSB11_LIMIT; // [RULE13]
      end
      AG_BIT_SB16: begin
        ea = {4'h0, 16'(st_ff.sb + disp)};
        rangeErr = disp > BSB16_LIMIT; // [RULE13]
      end
      AG_BIT_FB: begin
        ea = {4'h0, 16'(fbCur + disp)};
        rangeErr = !fitsSigned(disp, 5); // [RULE13]
      end
      default: ea = 20'h00000;
    endcase
  end

  // Each formed address is judged against the active mode.
  assign areaBus.addr = ea;
  assign areaBus.mode = crs_mode_t'(st_ff.mode); // [RULE23]

  // ==========================================================================
  // Next state
  logic addrPhase;
  logic [31:0] rv;
  logic [15:0] res;

  assign addrPhase = hsel && htrans[1] && hready;

  always_comb begin
    nxt_st = st_ff;
    rv = 32'h00000000;
    res = 16'h0000;

    // Read data is captured in the address phase, so it stands in the data phase.
    case (haddr[7:0])
      REG_R0: rv = {16'h0000, st_ff.bank[bnk][BK_R0]};
      REG_R1: rv = {16'h0000, st_ff.bank[bnk][BK_R1]};
      REG_R2: rv = {16'h0000, st_ff.bank[bnk][BK_R2]};
      REG_R3: rv = {16'h0000, st_ff.bank[bnk][BK_R3]};
      REG_A0: rv = {16'h0000, st_ff.bank[bnk][BK_A0]};
      REG_A1: rv = {16'h0000, st_ff.bank[bnk][BK_A1]};
      REG_FB: rv = {16'h0000, st_ff.bank[bnk][BK_FB]};

      REG_SB: rv = {16'h0000, st_ff.sb};
      REG_USP: rv = {16'h0000, st_ff.user_stack_pointer};
      REG_ISP: rv = {16'h0000, st_ff.interrupt_stack_pointer};
      REG_FLG: rv = {16'h0000, st_ff.flag_word};
      REG_PC: rv = {12'h000, st_ff.pc}; // [RULE3]
      REG_VECTOR_TABLE_BASE: rv = {12'h000, st_ff.vector_table_base}; // [RULE3]

      // Pair and byte views of the current bank.
      REG_R2R0: rv = {st_ff.bank[bnk][BK_R2], st_ff.bank[bnk][BK_R0]}; // [RULE2]
      REG_R3R1: rv = {st_ff.bank[bnk][BK_R3], st_ff.bank[bnk][BK_R1]}; // [RULE2]
      REG_A1A0: rv = {st_ff.bank[bnk][BK_A1], st_ff.bank[bnk][BK_A0]};
      REG_R0L: rv = {24'h000000, st_ff.bank[bnk][BK_R0][7:0]}; // [RULE2]
      REG_R0H: rv = {24'h000000, st_ff.bank[bnk][BK_R0][15:8]};
      REG_R1L: rv = {24'h000000, st_ff.bank[bnk][BK_R1][7:0]};
      REG_R1H: rv = {24'h000000, st_ff.bank[bnk][BK_R1][15:8]};

      REG_MODE: rv = {30'h00000000, st_ff.mode};
      REG_AGU_CMD: rv = st_ff.aguCmd;
      REG_AGU_RES: rv = {4'h0, !areaBus.allowed, areaBus.area, rangeErr,
                         st_ff.aguCmd[7:5], ea};
      REG_SAVE: rv = {12'h000, st_ff.savePcHi, st_ff.saveFlg};
      REG_INSN: rv = {16'h0000, st_ff.unitCnt, st_ff.insnLen};
      default: rv = 32'h00000000;
    endcase
    if (addrPhase && !hwrite) begin
      nxt_st.rdata = rv;
    end

    nxt_st.wrPend = addrPhase && hwrite;
    nxt_st.wrAddr = haddr[7:0];

    // Software writes land first so that hardware events below win the cycle.
    if (st_ff.wrPend) begin
      case (st_ff.wrAddr)
        REG_R0: nxt_st.bank[bnk][BK_R0] = hwdata[15:0]; // [RULE1]
        REG_R1: nxt_st.bank[bnk][BK_R1] = hwdata[15:0];
        REG_R2: nxt_st.bank[bnk][BK_R2] = hwdata[15:0];
        REG_R3: nxt_st.bank[bnk][BK_R3] = hwdata[15:0];
        REG_A0: nxt_st.bank[bnk][BK_A0] = hwdata[15:0];
        REG_A1: nxt_st.bank[bnk][BK_A1] = hwdata[15:0];
        REG_FB: nxt_st.bank[bnk][BK_FB] = hwdata[15:0];

        REG_SB: nxt_st.sb = hwdata[15:0];
        REG_USP: nxt_st.user_stack_pointer = hwdata[15:0];
        REG_ISP: nxt_st.interrupt_stack_pointer = hwdata[15:0];
        // Flipping the bank flag only moves the bank index; shared state stays.
        REG_FLG: nxt_st.flag_word = hwdata[15:0]; // [RULE24]
        REG_PC: nxt_st.pc = hwdata[19:0]; // [RULE3]
        REG_VECTOR_TABLE_BASE: nxt_st.vector_table_base = hwdata[19:0]; // [RULE3]

        REG_R2R0: begin
          nxt_st.bank[bnk][BK_R0] = hwdata[15:0]; // [RULE2]
          nxt_st.bank[bnk][BK_R2] = hwdata[31:16];
        end
        REG_R3R1: begin
          nxt_st.bank[bnk][BK_R1] = hwdata[15:0]; // [RULE2]
          nxt_st.bank[bnk][BK_R3] = hwdata[31:16];
        end
        REG_A1A0: begin
          nxt_st.bank[bnk][BK_A0] = hwdata[15:0];
          nxt_st.bank[bnk][BK_A1] = hwdata[31:16];
        end
        REG_R0L: nxt_st.bank[bnk][BK_R0][7:0] = hwdata[7:0]; // [RULE2]
        REG_R0H: nxt_st.bank[bnk][BK_R0][15:8] = hwdata[7:0];
        REG_R1L: nxt_st.bank[bnk][BK_R1][7:0] = hwdata[7:0];
        REG_R1H: nxt_st.bank[bnk][BK_R1][15:8] = hwdata[7:0];

        // Result, save and length words are read only.
        REG_MODE: nxt_st.mode = hwdata[1:0]; // [RULE23]
        REG_AGU_CMD: nxt_st.aguCmd = hwdata;
        default: nxt_st.mode = st_ff.mode;
      endcase
    end

    // ========================================================================
    // Operation results update the condition flags.
    if (aluValid) begin
      res = aluWide ? aluResult : {8'h00, aluResult[7:0]};
      nxt_st.flag_word[FLG_O] = aluOverflow; // [RULE5]
      nxt_st.flag_word[FLG_S] = aluWide ? res[15] : res[7]; // [RULE6]
      nxt_st.flag_word[FLG_Z] = (res == 16'h0000); // [RULE7]
    end

    // The save area keeps the flag word and the PC bits the stack frame lacks.
    if (intEvent) begin
      nxt_st.savePcHi = st_ff.pc[19:16]; // [RULE4]
      nxt_st.saveFlg = st_ff.flag_word;
    end

    // ========================================================================
    // Instruction length in opcode units and the single-step break.
    // The break pulse lasts one cycle.
    nxt_st.stepBreak = 1'b0;
    if (insnDone) begin
      nxt_st.insnLen = 8'(st_ff.unitCnt + {7'h00, opUnitValid}); // [RULE17]
      nxt_st.unitCnt = 8'h00;
      nxt_st.stepBreak = st_ff.flag_word[FLG_D]; // [RULE8]
    end else if (opUnitValid) begin
      nxt_st.unitCnt = 8'(st_ff.unitCnt + 8'h01); // [RULE17]
    end
  end

  // Flag-word and mode reset values come from the package; all else clears to zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.flag_word <= FLG_RESET;
      st_ff.mode <= MODE_SINGLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata = st_ff.rdata;
  // Zero wait states; every answer is OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign stepBreak = st_ff.stepBreak;
  assign singleStep = st_ff.flag_word[FLG_D]; // [RULE8]
  assign bankSel = st_ff.flag_word[FLG_B];
  assign opMode = st_ff.mode;
  assign flagWord = st_ff.flag_word;
endmodule : crs_regset
`default_nettype wire

/* crs_regset_chk.sv */
/*
  Concurrent checks on the flag word, bank select and single-step outputs of
  the core register set. Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module crs_regset_chk
  import crs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic aluValid,
  input wire logic aluWide,
  input wire logic [15:0] aluResult,
  input wire logic aluOverflow,
  input wire logic insnDone,
  input wire logic stepBreak,
  input wire logic singleStep,
  input wire logic bankSel,
  input wire logic [15:0] flagWord
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_bank;
    bankSel == flagWord[FLG_B];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select differs from flag");
  property p_dbg;
    singleStep == flagWord[FLG_D];
  endproperty
  a_dbg: assert property (p_dbg) else $error("step level differs from flag");
  property p_step;
    insnDone && flagWord[FLG_D] |=> stepBreak;
  endproperty
  a_step: assert property (p_step) else $error("no step pulse after instruction");
  property p_nostep;
    stepBreak |-> $past(insnDone) && $past(flagWord[FLG_D]);
  endproperty
  a_nostep: assert property (p_nostep) else $error("step pulse without cause");
  property p_ovf;
    aluValid && aluOverflow |=> flagWord[FLG_O];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");
  property p_zero;
    aluValid && aluWide && aluResult == 16'h0000 |=> flagWord[FLG_Z];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag not set");
  property p_nz;
    aluValid && (aluWide ? aluResult != 16'h0000 : aluResult[7:0] != 8'h00) |=> !flagWord[FLG_Z];
  endproperty
  a_nz: assert property (p_nz) else $error("zero flag set on nonzero");
  property p_sign16;
    aluValid && aluWide |=> flagWord[FLG_S] == $past(aluResult[15]);
  endproperty
  a_sign16: assert property (p_sign16) else $error("sign flag wrong, word");
  property p_sign8;
    aluValid && !aluWide |=> flagWord[FLG_S] == $past(aluResult[7]);
  endproperty
  a_sign8: assert property (p_sign8) else $error("sign flag wrong, byte");
endmodule : crs_regset_chk

bind crs_regset crs_regset_chk chk_u (.clock(clock), .rst_n(rst_n), .aluValid(aluValid),
  .aluWide(aluWide), .aluResult(aluResult), .aluOverflow(aluOverflow), .insnDone(insnDone),
  .stepBreak(stepBreak), .singleStep(singleStep), .bankSel(bankSel), .flagWord(flagWord));
`default_nettype wire

/* cpu_register_set_and_memory_map_bench.sv */
/*
  Self-checking bench for the core register set over its AHB-Lite port.
  Assumes the package, interface, decoder, register set and checker come first.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_and_memory_map_bench;
  import crs_pkg::*;
  logic clock, rst_n, hsel, hwrite, intEvent, aluValid, aluWide, aluOverflow;
  logic opUnitValid, insnDone, hreadyout, hresp, stepBreak, singleStep, bankSel, blk;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, opMode;
  logic [2:0] hsize;
  logic [15:0] aluResult, flagWord;
  int badCount = 0, numChecks = 0, i, j;
  logic [7:0] wa[5] = '{REG_PC, REG_VECTOR_TABLE_BASE, REG_USP, REG_ISP, REG_R1};
  logic [31:0] wm[5] = '{32'hFFFFF, 32'hFFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF};
  logic [16:0] ar[5] = '{17'h10000, 17'h18000, 17'h00180, 17'h00100, 17'h10001};
  logic [15:0] ef[5] = '{16'h04, 16'h28, 16'h08, 16'h24, 16'h00};
  logic [0:4] ao = 5'h0A;
  logic [1:0] md[3] = '{2'b00, 2'b01, 2'b11};
  logic [19:0] ad[5] = '{20'h00010, 20'h00500, 20'hF8000, 20'hFFE10, 20'h20000};
  logic [3:0] rm[11] = '{AG_BIT_ABS, AG_BIT_ABS, AG_BIT_FB, AG_BIT_FB, AG_GEN_SB8,
    AG_GEN_SB8, AG_PC_S, AG_PC_S, AG_BIT_SB8, AG_GEN_FB, AG_SPC_SP};
  logic [15:0] rv[11] = '{16'h1FFF, 16'h2000, 16'hFFF0, 16'hFFEF, 16'h00FF, 16'h0100,
    16'h0001, 16'h0009, 16'h0020, 16'hFF80, 16'h0080};
  logic [0:10] re = 11'h2B5;

  crs_regset dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .intEvent(intEvent),
    .aluValid(aluValid), .aluWide(aluWide), .aluResult(aluResult),
    .aluOverflow(aluOverflow), .opUnitValid(opUnitValid), .insnDone(insnDone),
    .stepBreak(stepBreak), .singleStep(singleStep), .bankSel(bankSel), .opMode(opMode),
    .flagWord(flagWord));

  // ==========================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      badCount++;
    end
  endtask : check

  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : completeRun

  // A zero-wait slave still gets a bounded wait, so a stuck ready shows up.
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      badCount++;
      completeRun();
    end
  endtask : waitRdy

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("register %h", a), exp, q);
    check("response", 32'h0, {31'h0, hresp});
  endtask : rd

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    completeRun();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, intEvent, aluValid, aluWide} = '0;
    {aluResult, aluOverflow, opUnitValid, insnDone, rst_n} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_FLG, 32'h0);
    rd(REG_MODE, 32'h0);
    for (i = 0; i < 5; i++) begin
      bus(1'b1, wa[i], 32'hFFFFFFFF);
      rd(wa[i], wm[i]);
    end
    bus(1'b1, REG_R2R0, 32'h12345678);
    rd(REG_R0, 32'h5678);
    rd(REG_R2, 32'h1234);
    bus(1'b1, REG_R0L, 32'hAB);
    rd(REG_R0, 32'h56AB);
    rd(REG_R0H, 32'h56);
    bus(1'b1, REG_R1H, 32'hCD);
    rd(REG_R3R1, 32'hCDFF);
    bus(1'b1, REG_A1A0, 32'h9ABCDEF0);
    rd(REG_A1, 32'h9ABC);
    // Fill bank 0, flip to bank 1, then come back; shared registers must not move.
    for (i = 0; i < 7; i++) bus(1'b1, 8'(i * 4), 32'h1100 + i);
    bus(1'b1, REG_SB, 32'h55);
    bus(1'b1, REG_FLG, 32'h10);
    for (i = 0; i < 7; i++) begin
      rd(8'(i * 4), 32'h0);
      bus(1'b1, 8'(i * 4), 32'h2200 + i);
    end
    check("bank select", 32'h1, {31'h0, bankSel});
    rd(REG_SB, 32'h55);
    rd(REG_USP, 32'hFFFF);
    bus(1'b1, REG_FLG, 32'h0);
    for (i = 0; i < 7; i++) rd(8'(i * 4), 32'h1100 + i);
    for (i = 0; i < 5; i++) begin
      aluValid <= 1'b1;
      {aluWide, aluResult} <= ar[i];
      aluOverflow <= ao[i];
      @(posedge clock);
      aluValid <= 1'b0;
      @(negedge clock);
      check("flags", {16'h0, ef[i]}, {16'h0, flagWord & 16'h002C});
      @(posedge clock);
    end
    for (i = 0; i < 2; i++) begin
      bus(1'b1, REG_FLG, (i == 0) ? 32'h2 : 32'h0);
      opUnitValid <= 1'b1;
      repeat (3) @(posedge clock);
      insnDone <= 1'b1;
      @(posedge clock);
      {opUnitValid, insnDone} <= 2'b00;
      @(negedge clock);
      check("step pulse", (i == 0) ? 32'h1 : 32'h0, {31'h0, stepBreak});
      check("step level", (i == 0) ? 32'h1 : 32'h0, {31'h0, singleStep});
      @(posedge clock);
      rd(REG_INSN, 32'h4);
    end
    bus(1'b1, REG_PC, 32'hA1234);
    bus(1'b1, REG_FLG, 32'hC1);
    intEvent <= 1'b1;
    @(posedge clock);
    intEvent <= 1'b0;
    rd(REG_SAVE, 32'hA00C1);
    bus(1'b1, REG_FLG, 32'h0);
    for (i = 0; i < 3; i++) begin
      bus(1'b1, REG_MODE, {30'h0, md[i]});
      for (j = 0; j < 5; j++) begin
        blk = (i == 0 && j == 4) || (i == 2 && (j == 2 || j == 3));
        bus(1'b1, REG_AGU_CMD, {ad[j][15:0], 4'h0, ad[j][19:16], 8'h05});
        rd(REG_AGU_RES, {4'h0, blk, 3'(j), 4'h0, ad[j]});
      end
      check("mode", {30'h0, md[i]}, {30'h0, opMode});
    end
    for (i = 0; i < 11; i++) begin
      bus(1'b1, REG_AGU_CMD, {rv[i], 12'h000, rm[i]});
      bus(1'b0, REG_AGU_RES, 32'h0);
      check("range error", 32'(re[i]), 32'(q[23]));
    end
    bus(1'b1, REG_AGU_CMD, {16'h1234, 4'h0, 4'hF, 4'h0, AG_GEN_ABS});
    rd(REG_AGU_RES, 32'h01001234);
    completeRun();
  end
endmodule : cpu_register_set_and_memory_map_bench
`default_nettype wire
